// ==== logic/mcal_pkg.sv ====
// Package: command codes, timing constants and carriers for the measure/calibrate engine
package mcal_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ          = 25;
    localparam int REG_STEP_US      = 300;
    localparam int REG_STEP_CYC     = REG_STEP_US * CLK_MHZ;
    localparam int REG_MAX_US       = 5000;
    localparam int REG_MAX_CYC      = REG_MAX_US * CLK_MHZ;
    localparam int MOD_MAX_US       = 275;
    localparam int MOD_MAX_CYC      = MOD_MAX_US * CLK_MHZ;
    localparam int ANT_MAX_US       = 250;
    localparam int ANT_MAX_CYC      = ANT_MAX_US * CLK_MHZ;
    localparam int MEAS_MAX_US      = 25;
    localparam int MEAS_MAX_CYC     = MEAS_MAX_US * CLK_MHZ;
    localparam int CSCAL_MAX_US     = 3000;
    localparam int CSCAL_MAX_CYC    = CSCAL_MAX_US * CLK_MHZ;
    localparam int CAP_MAX_US       = 250;
    localparam int CAP_MAX_CYC      = CAP_MAX_US * CLK_MHZ;
    localparam int SETTLE_CYC       = 16;

    // ------------------------------------------------------------------
    // Regulator settings, in mV
    // ------------------------------------------------------------------
    localparam logic [12:0] REG5_TOP_MV  = 13'd5100;
    localparam logic [12:0] REG5_MIN_MV  = 13'd3900;
    localparam logic [12:0] REG5_STEP_MV = 13'd120;
    localparam logic [12:0] REG3_TOP_MV  = 13'd3400;
    localparam logic [12:0] REG3_MIN_MV  = 13'd2400;
    localparam logic [12:0] REG3_STEP_MV = 13'd100;
    localparam logic [12:0] HEADROOM_MV  = 13'd250;

    // ------------------------------------------------------------------
    // Results
    // ------------------------------------------------------------------
    localparam logic [7:0] PHASE_SAT_LOW_ANGLE = 8'hFF;
    localparam logic [7:0] PHASE_SAT_HIGH_ANGLE = 8'h00;
    localparam logic [7:0] ADC_RESET = 8'h00;
    localparam logic [7:0] RSSI_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Commands
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_ADJ_REG   = 4'h1,
        CMD_CAL_MOD   = 4'h2,
        CMD_CAL_ANT   = 4'h3,
        CMD_MEAS_PH   = 4'h4,
        CMD_CLR_RSSI  = 4'h5,
        CMD_TRANSP    = 4'h6,
        CMD_CAL_CS    = 4'h7,
        CMD_MEAS_CAP  = 4'h8,
        CMD_MEAS_SUP  = 4'h9
    } cmd_t;

    // Analog front-end handshake: request a conversion, receive a result
    typedef struct packed {
        logic       rx_on;
        logic       tx_on;
        logic       phase_det;
        logic       mod_cal;
        logic       ant_cal;
        logic       cs_cal;
        logic       cs_meas;
        logic       adc_relative;
        logic [1:0] supply_sel;
    } afe_ctrl_t;

    typedef struct packed {
        logic       done;
        logic [7:0] value;
    } afe_result_t;

endpackage

// ==== logic/cycle_timer.sv ====
// Down-counting timer with one-cycle expiry pulse
`timescale 1ns/100ps
module cycle_timer
    import mcal_pkg::*;
#(
    parameter int WIDTH = 18
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    // Control
    input  wire logic             i_load,
    input  wire logic [WIDTH-1:0] i_count,
    input  wire logic             i_stop,
    // Status
    output logic                  o_expired,
    output logic                  o_running
);

    logic [WIDTH-1:0] count_q;
    logic             run_q;
    wire              last_w = run_q && (count_q == WIDTH'(1));

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count_q   <= '0;
            run_q     <= 1'b0;
            o_expired <= 1'b0;
        end else begin
            o_expired <= last_w && !i_load && !i_stop;
            if (i_load) begin
                count_q <= i_count;
                run_q   <= 1'b1;
            end else if (i_stop || last_w) begin
                run_q   <= 1'b0;
            end else if (run_q) begin
                count_q <= count_q - WIDTH'(1);
            end
        end
    end

    assign o_running = run_q;

endmodule // cycle_timer

// ==== logic/phase_saturate.sv ====
// Clamps the phase converter code to its documented range
`timescale 1ns/100ps
module phase_saturate
    import mcal_pkg::*;
(
    // Raw converter data
    input  wire logic [7:0] i_raw,
    input  wire logic       i_below_range,
    input  wire logic       i_above_range,
    // Clamped code
    output logic [7:0]      o_code
);

    // Low angle reads all ones, high angle reads zero
    assign o_code = i_below_range ? PHASE_SAT_LOW_ANGLE :
                    i_above_range ? PHASE_SAT_HIGH_ANGLE : i_raw;

endmodule // phase_saturate

// ==== logic/measure_calibrate_cmd_engine.sv ====
// Sequencer for measurement and calibration direct commands
//
// Notes on behaviour
// - Regulator adjust: rx/tx on, top setting
// - Every 300 us compare, step down one
// - Regulator loop stops at minimum setting
// - Regulator adjust finishes within 5 ms
// - Refuse regulator adjust when external selected
// - Most commands need chip active, xtal stable
// - No chaining for long commands
// - Long commands raise termination interrupt
// - Modulation depth calibrate within 275 us
// - Antenna calibrate within 250 us
// - Phase measure, relative mode, within 25 us
// - Phase saturates FF low, 00 high
// - 90 degrees gives mid-range code
// - Receiver-on rise clears RSSI, starts peak-hold
// - RSSI clear restarts, chainable, no interrupt
// - Transparent mode from select rise while high
// - Sensor calibrate only with zero manual trims
// - Capacitance measure within 250 us
// - Supply measure: selected rail, absolute mode
// - Receiver-on gates RSSI peak-hold and framing
`timescale 1ns/100ps
module measure_calibrate_cmd_engine
    import mcal_pkg::*;
#(
    parameter int REG_STEP_CYCLES = REG_STEP_CYC,
    parameter int REG_MAX_CYCLES  = REG_MAX_CYC,
    parameter int CSCAL_CYCLES    = CSCAL_MAX_CYC
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    // Command strobe from the SPI decoder
    input  wire logic        i_cmd_valid,
    input  wire cmd_t        i_cmd,
    output logic             o_cmd_accept,
    output logic             o_busy,
    output logic             o_cmd_done_irq,
    // Configuration bits
    input  wire logic        i_chip_enable,
    input  wire logic        i_xtal_stable,
    input  wire logic        i_ext_reg_select,
    input  wire logic        i_supply_5v_mode,
    input  wire logic [3:0]  i_cs_manual_trim,
    input  wire logic        i_supply_select_high,
    input  wire logic        i_supply_select_low,
    input  wire logic        i_rx_on_req,
    // Pins from outside the clock domain
    input  wire logic        i_spi_ss_n,
    input  wire logic        i_rf_rail_low_enough,
    // Analog front end
    output afe_ctrl_t        o_afe_ctrl,
    input  wire afe_result_t i_afe_result,
    input  wire logic        i_phase_below_range,
    input  wire logic        i_phase_above_range,
    input  wire logic [7:0]  i_rssi_level,
    // Results
    output logic [12:0]      o_reg_setting_mv,
    output logic [7:0]       o_adc_result,
    output logic [7:0]       o_rssi_display,
    output logic             o_transparent,
    output logic             o_framing_enable
);

    // ------------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------------
    typedef enum logic [7:0] {
        ST_IDLE    = 8'b0000_0001,
        ST_REG     = 8'b0000_0010,
        ST_CONV    = 8'b0000_0100,
        ST_CAL     = 8'b0000_1000,
        ST_DONE    = 8'b0001_0000,
        ST_TP_ARM  = 8'b0010_0000,
        ST_TP_RUN  = 8'b0100_0000,
        ST_SETTLE  = 8'b1000_0000
    } state_t;

    state_t      state_q, state_d;
    cmd_t        cmd_q;
    logic [12:0] reg_mv_q;
    logic [7:0]  adc_q;
    logic [7:0]  rssi_q;
    logic        irq_q;
    logic [4:0]  settle_q;

    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    logic [1:0] ss_sync_q;
    logic [1:0] rail_sync_q;
    logic       ss_prev_q;
    logic       rx_prev_q;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ss_sync_q   <= 2'h3;
            rail_sync_q <= 2'h0;
            ss_prev_q   <= 1'b1;
            rx_prev_q   <= 1'b0;
        end else begin
            ss_sync_q   <= {ss_sync_q[0], i_spi_ss_n};
            rail_sync_q <= {rail_sync_q[0], i_rf_rail_low_enough};
            ss_prev_q   <= ss_sync_q[1];
            rx_prev_q   <= i_rx_on_req;
        end
    end

    wire ss_high_w = ss_sync_q[1];
    wire ss_rise_w = ss_sync_q[1] && !ss_prev_q;
    wire rail_ok_w = rail_sync_q[1];
    wire rx_rise_w = i_rx_on_req && !rx_prev_q;

    // ------------------------------------------------------------------
    // Acceptance decode
    // ------------------------------------------------------------------
    wire active_w   = i_chip_enable && i_xtal_stable;
    wire idle_w     = (state_q == ST_IDLE);
    wire chainable_w = (i_cmd == CMD_CLR_RSSI);
    // Long commands wait for idle; they are never chained
    wire free_w     = idle_w || (chainable_w && state_q != ST_TP_RUN);
    logic cond_w;

    always_comb begin
        case (i_cmd)
            CMD_ADJ_REG:  cond_w = active_w && !i_ext_reg_select;
            CMD_CAL_MOD,
            CMD_CAL_ANT,
            CMD_MEAS_PH,
            CMD_CLR_RSSI,
            CMD_TRANSP,
            CMD_MEAS_SUP: cond_w = active_w;
            CMD_CAL_CS:   cond_w = (i_cs_manual_trim == 4'h0);
            CMD_MEAS_CAP: cond_w = 1'b1;
            default:      cond_w = 1'b0;
        endcase
    end

    // Refused commands leave every register as it was
    wire accept_w     = i_cmd_valid && free_w && cond_w;
    wire start_w      = accept_w && !chainable_w;
    wire rssi_clear_w = (accept_w && chainable_w) || rx_rise_w;

    assign o_cmd_accept = accept_w;

    // ------------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------------
    logic        step_load, step_exp;
    logic        lim_load, lim_exp;
    logic [21:0] lim_count;
    wire         seq_end_w = (state_d == ST_DONE) && (state_q != ST_DONE);

    always_comb begin
        case (i_cmd)
            CMD_ADJ_REG:  lim_count = 22'(REG_MAX_CYCLES);
            CMD_CAL_MOD:  lim_count = 22'(MOD_MAX_CYC);
            CMD_CAL_ANT:  lim_count = 22'(ANT_MAX_CYC);
            CMD_CAL_CS:   lim_count = 22'(CSCAL_CYCLES);
            CMD_MEAS_CAP: lim_count = 22'(CAP_MAX_CYC);
            default:      lim_count = 22'(MEAS_MAX_CYC);
        endcase
    end

    assign lim_load  = start_w && (i_cmd != CMD_TRANSP);

    cycle_timer #(.WIDTH(22)) u_limit (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_load    (lim_load),
        .i_count   (lim_count),
        .i_stop    (seq_end_w),
        .o_expired (lim_exp),
        .o_running ()
    );

    cycle_timer #(.WIDTH(22)) u_step (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_load    (step_load),
        .i_count   (22'(REG_STEP_CYCLES)),
        .i_stop    (seq_end_w),
        .o_expired (step_exp),
        .o_running ()
    );

    // ------------------------------------------------------------------
    // Regulator stepping
    // ------------------------------------------------------------------
    wire [12:0] reg_top_w  = i_supply_5v_mode ? REG5_TOP_MV  : REG3_TOP_MV;
    wire [12:0] reg_min_w  = i_supply_5v_mode ? REG5_MIN_MV  : REG3_MIN_MV;
    wire [12:0] reg_step_w = i_supply_5v_mode ? REG5_STEP_MV : REG3_STEP_MV;
    wire        reg_at_min_w = (reg_mv_q <= reg_min_w);
    wire        reg_cmp_w  = (state_q == ST_REG) && step_exp;

    assign step_load = (start_w && i_cmd == CMD_ADJ_REG) ||
                       (state_q == ST_REG && step_exp && !rail_ok_w && !reg_at_min_w);

    // ------------------------------------------------------------------
    // Phase code clamp
    // ------------------------------------------------------------------
    logic [7:0] phase_code_w;

    phase_saturate u_phase (
        .i_raw         (i_afe_result.value),
        .i_below_range (i_phase_below_range),
        .i_above_range (i_phase_above_range),
        .o_code        (phase_code_w)
    );

    // Converter code is stored uninverted, phase code clamped first: 80h and up is under 90 deg
    wire [7:0] conv_value_w = (cmd_q == CMD_MEAS_PH) ? phase_code_w
                                                     : i_afe_result.value;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start_w) begin
                    case (i_cmd)
                        CMD_ADJ_REG: state_d = ST_REG;
                        CMD_TRANSP:  state_d = ST_TP_ARM;
                        CMD_CAL_MOD,
                        CMD_CAL_ANT,
                        CMD_CAL_CS:  state_d = ST_CAL;
                        default:     state_d = ST_SETTLE;
                    endcase
                end
            end
            ST_REG: begin
                if (lim_exp || (reg_cmp_w && (rail_ok_w || reg_at_min_w))) begin
                    state_d = ST_DONE;
                end
            end
            ST_SETTLE: begin
                if (settle_q == 5'(SETTLE_CYC - 1)) begin
                    state_d = ST_CONV;
                end else if (lim_exp) begin
                    state_d = ST_DONE;
                end
            end
            ST_CONV,
            ST_CAL: begin
                if (i_afe_result.done || lim_exp) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE:   state_d = ST_IDLE;
            ST_TP_ARM: begin
                if (ss_rise_w) begin
                    state_d = ST_TP_RUN;
                end
            end
            ST_TP_RUN: begin
                if (!ss_high_w) begin
                    state_d = ST_IDLE;
                end
            end
            default:   state_d = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q  <= ST_IDLE;
            cmd_q    <= CMD_MEAS_SUP;
            settle_q <= 5'h00;
            irq_q    <= 1'b0;
        end else begin
            state_q  <= state_d;
            settle_q <= (state_q == ST_SETTLE) ? settle_q + 5'h01 : 5'h00;
            irq_q    <= (state_q == ST_DONE);
            if (start_w) begin
                cmd_q <= i_cmd;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            reg_mv_q <= REG3_TOP_MV;
        end else if (start_w && i_cmd == CMD_ADJ_REG) begin
            reg_mv_q <= reg_top_w;
        end else if (reg_cmp_w && !rail_ok_w && !reg_at_min_w) begin
            reg_mv_q <= reg_mv_q - reg_step_w;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            adc_q <= ADC_RESET;
        end else if (state_q == ST_CONV && i_afe_result.done) begin
            adc_q <= conv_value_w;
        end
    end

    // Peak hold, gated by receiver on
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rssi_q <= RSSI_RESET;
        end else if (rssi_clear_w) begin
            rssi_q <= RSSI_RESET;
        end else if (i_rx_on_req && i_rssi_level > rssi_q) begin
            rssi_q <= i_rssi_level;
        end
    end

    // ------------------------------------------------------------------
    // Front-end control
    // ------------------------------------------------------------------
    wire reg_run_w  = (state_q == ST_REG);
    wire conv_run_w = (state_q == ST_SETTLE) || (state_q == ST_CONV);
    wire cal_run_w  = (state_q == ST_CAL);
    wire is_ph_w    = (cmd_q == CMD_MEAS_PH);

    assign o_afe_ctrl.rx_on        = i_rx_on_req || reg_run_w;
    assign o_afe_ctrl.tx_on        = reg_run_w || (conv_run_w && is_ph_w) ||
                                     (cal_run_w && cmd_q != CMD_CAL_CS);
    assign o_afe_ctrl.phase_det    = conv_run_w && is_ph_w;
    assign o_afe_ctrl.mod_cal      = cal_run_w && cmd_q == CMD_CAL_MOD;
    assign o_afe_ctrl.ant_cal      = cal_run_w && cmd_q == CMD_CAL_ANT;
    assign o_afe_ctrl.cs_cal       = cal_run_w && cmd_q == CMD_CAL_CS;
    assign o_afe_ctrl.cs_meas      = conv_run_w && cmd_q == CMD_MEAS_CAP;
    assign o_afe_ctrl.adc_relative = is_ph_w;
    assign o_afe_ctrl.supply_sel   = {i_supply_select_high, i_supply_select_low};

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_busy           = !idle_w;
    assign o_cmd_done_irq   = irq_q;
    assign o_reg_setting_mv = reg_mv_q;
    assign o_adc_result     = adc_q;
    assign o_rssi_display   = rssi_q;
    assign o_transparent    = (state_q == ST_TP_RUN);
    assign o_framing_enable = i_rx_on_req;

endmodule // measure_calibrate_cmd_engine

// ==== testbench/afe_model.sv ====
// Behavioural analog front end: answers a running command with one result
`timescale 1ns/100ps
module afe_model
    import mcal_pkg::*;
(
    // Clock and reset
    input  wire logic  i_clk,
    input  wire logic  i_reset_n,
    // Request and answer shaping
    input  wire logic  i_active,
    input  wire logic [7:0] i_value,
    input  wire logic [7:0] i_delay,
    // Result towards the engine
    output afe_result_t o_result
);
    logic [7:0] cnt_q;
    logic       fired_q;
    wire        done_w = i_active && !fired_q && cnt_q == i_delay;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n || !i_active) begin
            cnt_q   <= 8'h00;
            fired_q <= 1'b0;
        end else if (!fired_q) begin
            cnt_q   <= cnt_q + 8'h01;
            fired_q <= done_w;
        end
    end

    // Data is only valid with done; otherwise show the inverse
    assign o_result = '{done: done_w, value: done_w ? i_value : ~i_value};
endmodule // afe_model

// ==== testbench/mcal_chk.sv ====
// Assertions on the ports of the measure/calibrate command engine
`timescale 1ns/100ps
module mcal_chk
    import mcal_pkg::*;
#(
    parameter int REG_STEP_CYCLES = 20,
    parameter int REG_MAX_CYCLES  = 500,
    parameter int CSCAL_CYCLES    = 200
) (
    input wire logic i_clk, i_reset_n, i_cmd_valid,
    input wire cmd_t i_cmd,
    input wire logic o_cmd_accept, o_busy, o_cmd_done_irq,
    input wire logic i_chip_enable, i_xtal_stable, i_ext_reg_select,
    input wire logic i_supply_5v_mode, i_supply_select_high, i_supply_select_low,
    input wire logic [3:0] i_cs_manual_trim,
    input wire logic i_rx_on_req, o_framing_enable,
    input wire afe_ctrl_t o_afe_ctrl,
    input wire logic [12:0] o_reg_setting_mv,
    input wire logic [7:0] o_rssi_display
);
    localparam int PH_MAX = 627;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    wire        ready_w = i_chip_enable && i_xtal_stable;
    wire        gated_w = i_cmd inside {[CMD_ADJ_REG:CMD_TRANSP], CMD_MEAS_SUP};
    wire [12:0] top_w   = i_supply_5v_mode ? REG5_TOP_MV : REG3_TOP_MV;
    wire [12:0] min_w   = i_supply_5v_mode ? REG5_MIN_MV : REG3_MIN_MV;
    wire [12:0] step_w  = i_supply_5v_mode ? REG5_STEP_MV : REG3_STEP_MV;
    wire        ph_w    = o_cmd_accept && i_cmd == CMD_MEAS_PH;

    busy_refuse_a: assert property (i_cmd_valid && o_busy && i_cmd != CMD_CLR_RSSI
        |-> !o_cmd_accept) else $error("command taken while busy");
    enable_refuse_a: assert property (i_cmd_valid && gated_w && !ready_w
        |-> !o_cmd_accept) else $error("command taken while disabled");
    ext_refuse_a: assert property (i_cmd_valid && i_cmd == CMD_ADJ_REG && i_ext_reg_select
        |-> !o_cmd_accept) else $error("regulator adjust taken with external select");
    trim_refuse_a: assert property (i_cmd_valid && i_cmd == CMD_CAL_CS && i_cs_manual_trim != 4'h0
        |-> !o_cmd_accept) else $error("sensor calibrate taken with manual trim");
    reg_top_a: assert property (o_cmd_accept && i_cmd == CMD_ADJ_REG |=> o_reg_setting_mv == top_w
        && o_afe_ctrl.rx_on && o_afe_ctrl.tx_on) else $error("regulator not at top");
    reg_step_a: assert property ($changed(o_reg_setting_mv) && !$past(o_cmd_accept)
        |-> o_reg_setting_mv == $past(o_reg_setting_mv) - step_w) else $error("bad step");
    reg_floor_a: assert property ($changed(o_reg_setting_mv) && !$past(o_cmd_accept)
        |-> o_reg_setting_mv >= min_w) else $error("regulator below minimum");
    irq_pulse_a: assert property (o_cmd_done_irq |=> !o_cmd_done_irq)
        else $error("interrupt longer than one cycle");
    rssi_quiet_a: assert property (o_cmd_accept && i_cmd == CMD_CLR_RSSI && !o_busy
        |=> !o_cmd_done_irq [*3]) else $error("interrupt after rssi clear");
    rssi_rise_a: assert property ($rose(i_rx_on_req) |-> ##[1:2] o_rssi_display == RSSI_RESET)
        else $error("rssi not cleared");
    phase_ctrl_a: assert property (ph_w |=> o_afe_ctrl.tx_on && o_afe_ctrl.phase_det
        && o_afe_ctrl.adc_relative) else $error("phase enables wrong");
    phase_time_a: assert property (ph_w |-> ##[1:PH_MAX] o_cmd_done_irq)
        else $error("phase measure too slow");
    supply_ctrl_a: assert property (o_cmd_accept && i_cmd == CMD_MEAS_SUP |=> !o_afe_ctrl.adc_relative
        && o_afe_ctrl.supply_sel == {i_supply_select_high, i_supply_select_low}) else $error("supply setup");
    framing_a: assert property (o_framing_enable == i_rx_on_req)
        else $error("framing enable wrong");
    cover property (ph_w ##[1:PH_MAX] o_cmd_done_irq);
    cover property (i_cmd_valid && o_busy && !o_cmd_accept);
    cover property (o_cmd_accept && i_cmd == CMD_ADJ_REG);
endmodule // mcal_chk

bind measure_calibrate_cmd_engine mcal_chk #(.REG_STEP_CYCLES(REG_STEP_CYCLES),
    .REG_MAX_CYCLES(REG_MAX_CYCLES), .CSCAL_CYCLES(CSCAL_CYCLES)) mcal_chk_inst (.*);

// ==== testbench/measure_calibrate_cmd_engine_tb_top.sv ====
// Self-checking bench for the measure/calibrate command engine
`timescale 1ns/100ps
module measure_calibrate_cmd_engine_tb_top import mcal_pkg::*;;
    typedef struct {cmd_t c; logic en; logic ext; logic [3:0] trim; logic acc; logic irq;} row_t;
    logic clk, rst_n, valid, en, xtal, ext, m5, ss_n, rail, rx, sh, sl, below, above;
    cmd_t cmd;
    logic [3:0] trim;
    logic [7:0] lvl, value, delay, adc, rssi;
    logic [12:0] reg_mv;
    logic accept, busy, irq, transp, framing;
    afe_ctrl_t ctrl;
    afe_result_t res;
    int errors, checked, cycles, k;
    row_t rows [17] = '{'{CMD_ADJ_REG,1,0,0,1,1}, '{CMD_ADJ_REG,1,1,0,0,0}, '{CMD_ADJ_REG,0,0,0,0,0},
        '{CMD_CAL_MOD,1,0,0,1,1}, '{CMD_CAL_MOD,0,0,0,0,0}, '{CMD_CAL_ANT,1,0,0,1,1},
        '{CMD_CAL_ANT,0,0,0,0,0}, '{CMD_MEAS_PH,1,0,0,1,1}, '{CMD_MEAS_PH,0,0,0,0,0},
        '{CMD_CLR_RSSI,1,0,0,1,0}, '{CMD_CLR_RSSI,0,0,0,0,0}, '{CMD_TRANSP,0,0,0,0,0},
        '{CMD_CAL_CS,0,0,0,1,1}, '{CMD_CAL_CS,0,0,4'h5,0,0}, '{CMD_MEAS_CAP,0,0,0,1,1},
        '{CMD_MEAS_SUP,1,0,0,1,1}, '{CMD_MEAS_SUP,0,0,0,0,0}};

    measure_calibrate_cmd_engine #(.REG_STEP_CYCLES(20), .REG_MAX_CYCLES(500), .CSCAL_CYCLES(200))
        measure_calibrate_cmd_engine_inst (.i_clk(clk), .i_reset_n(rst_n), .i_cmd_valid(valid),
        .i_cmd(cmd), .o_cmd_accept(accept), .o_busy(busy), .o_cmd_done_irq(irq),
        .i_chip_enable(en), .i_xtal_stable(xtal), .i_ext_reg_select(ext), .i_supply_5v_mode(m5),
        .i_cs_manual_trim(trim), .i_supply_select_high(sh), .i_supply_select_low(sl),
        .i_rx_on_req(rx), .i_spi_ss_n(ss_n), .i_rf_rail_low_enough(rail), .o_afe_ctrl(ctrl),
        .i_afe_result(res), .i_phase_below_range(below), .i_phase_above_range(above),
        .i_rssi_level(lvl), .o_reg_setting_mv(reg_mv), .o_adc_result(adc),
        .o_rssi_display(rssi), .o_transparent(transp), .o_framing_enable(framing));
    afe_model afe_model_inst (.i_clk(clk), .i_reset_n(rst_n), .i_active(busy), .i_value(value),
        .i_delay(delay), .o_result(res));

    task automatic cmp(string what, logic [23:0] exp, logic [23:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic finish_cmd(logic irq_e);
        int n, idle;
        logic got;
        got = 0;
        idle = 0;
        for (n = 0; n < 2000 && idle < 4; n++) begin
            @(negedge clk);
            got |= irq;
            idle = busy ? 0 : idle + 1;
        end
        cmp("irq", irq_e, got);
    endtask
    task automatic run(cmd_t c, logic acc_e, logic irq_e);
        @(posedge clk);
        valid <= 1'b1;
        cmd <= c;
        @(negedge clk);
        cmp("accept", acc_e, accept);
        @(posedge clk);
        valid <= 1'b0;
        finish_cmd(irq_e);
    endtask
    task automatic conclude;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors++;
            conclude();
        end
    end

    initial begin
        {rst_n, valid, en, ext, m5, ss_n, rx, sh, sl, below, above} = '0;
        {xtal, rail, trim, lvl, value, delay} = {2'b11, 4'h0, 8'h33, 8'h80, 8'h18};
        cmd = CMD_ADJ_REG;
        {errors, checked, cycles} = '0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        cmp("reset", {1'b0, 1'b0, 1'b0, ADC_RESET, RSSI_RESET}, {busy, irq, transp, adc, rssi});
        cmp("reset reg", REG3_TOP_MV, reg_mv);
        @(posedge clk) rst_n <= 1'b1;
        for (k = 0; k < 17; k++) begin
            {en, ext, trim} <= {rows[k].en, rows[k].ext, rows[k].trim};
            run(rows[k].c, rows[k].acc, rows[k].irq);
            $display("row %0d done", k);
        end
        en <= 1'b1;
        for (k = 0; k < 3; k++) begin
            {below, above} <= {k == 0, k == 1};
            run(CMD_MEAS_PH, 1'b1, 1'b1);
            cmp("phase", k == 0 ? 8'hFF : (k == 1 ? 8'h00 : 8'h80), adc);
        end
        {below, above, sh, value} <= {2'b00, 1'b1, 8'h5A};
        run(CMD_MEAS_SUP, 1'b1, 1'b1);
        cmp("supply", 8'h5A, adc);
        $display("result tests done");
        delay <= 8'h3C;
        @(posedge clk) valid <= 1'b1;
        cmd <= CMD_MEAS_PH;
        @(posedge clk) cmd <= CMD_CAL_MOD;
        @(negedge clk) cmp("busy refuse", 1'b0, accept);
        @(posedge clk) cmd <= CMD_CLR_RSSI;
        @(negedge clk) cmp("chain accept", 1'b1, accept);
        @(posedge clk) valid <= 1'b0;
        finish_cmd(1'b1);
        $display("busy tests done");
        rail <= 1'b0;
        for (k = 0; k < 2; k++) begin
            m5 <= k[0];
            run(CMD_ADJ_REG, 1'b1, 1'b1);
            cmp("reg floor", k ? REG5_MIN_MV : REG3_MIN_MV, reg_mv);
        end
        rail <= 1'b1;
        run(CMD_ADJ_REG, 1'b1, 1'b1);
        cmp("reg top", REG5_TOP_MV, reg_mv);
        $display("regulator tests done");
        @(posedge clk) rx <= 1'b1;
        repeat (4) @(negedge clk);
        cmp("rssi peak", 8'h33, rssi);
        cmp("framing", 1'b1, framing);
        lvl <= 8'h11;
        run(CMD_CLR_RSSI, 1'b1, 1'b0);
        cmp("rssi clear", 8'h11, rssi);
        run(CMD_TRANSP, 1'b1, 1'b0);
        @(posedge clk) ss_n <= 1'b1;
        repeat (5) @(negedge clk);
        cmp("transparent on", 1'b1, transp);
        @(posedge clk) ss_n <= 1'b0;
        repeat (5) @(negedge clk);
        cmp("transparent off", 1'b0, transp);
        $display("receiver and transparent tests done");
        conclude();
    end
endmodule // measure_calibrate_cmd_engine_tb_top
